// ==== rtl/flyback_consts.svh ====
// timing figures, fault counts and input bit positions of the fault restart sequencer
`ifndef FLYBACK_CONSTS_SVH
`define FLYBACK_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define CS_CHECK_NS 4000
`define SOFTSHORT_HOLD_MS 120
`define FAULT_CONSEC 3
`define STARTUP_CYCLES 3
`define SOFTSHORT_SKIP_LOCKOUTS 3

`define IX_VDD_ON 0
`define IX_VDD_OFF 1
`define IX_CYCLE_END 2
`define IX_GATE 3
`define IX_VSENSE_OVER 4
`define IX_LINE_RUN 5
`define IX_LINE_STOP 6
`define IX_CS_OVER 7
`define IX_CS_MIN 8
`define IX_NTC_LOW 9
`define IX_OVER_TEMP 10
`define IX_CC_MODE 11
`define IX_VSENSE_LOW 12
`define IX_VSENSE_OPEN 13
`define IX_PEAK_LOW 14
`define NUM_INPUTS 15

`define CH_OVERVOLT 0
`define CH_LINE 1
`define CH_OC 2
`define CH_NTC 3
`define NUM_CHANNELS 4

`endif

// ==== rtl/flyback_pkg.sv ====
// types shared by the fault restart sequencer
package flyback_pkg;
	typedef enum logic [1:0] {SEQ_START, SEQ_RUN, SEQ_FAULT} seq_t;
endpackage : flyback_pkg

// ==== rtl/consec_counter.sv ====
// counts switching cycles on which one fault condition holds in a row
`timescale 1ns/10ps
`default_nettype none
module consec_counter #(
	parameter int N = 3,
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clear,
	input wire logic strobe,
	input wire logic cond,
	output logic hit
);
	typedef struct packed {
		logic [W-1:0] count;
	} cnt_state_t;

	cnt_state_t r;
	cnt_state_t next_r;

	// one cycle breaks the run, a restart empties it
	always_comb begin
		next_r = r;
		if (clear) begin
			next_r.count = '0;
		end else if (strobe && !cond) begin
			next_r.count = '0;
		end else if (strobe && cond && r.count != W'(N)) begin
			next_r.count = r.count + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// fires on the strobe that completes the run
	assign hit = !clear && strobe && cond && (r.count == W'(N - 1));

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	count_clear_a: assert property (clear || (strobe && !cond) |=> r.count == '0)
		else $error("run count not emptied");
	hit_full_run_a: assert property (hit |=> r.count == W'(N))
		else $error("hit without full run");
endmodule : consec_counter
`default_nettype wire

// ==== rtl/fault_restart_sequencer.sv ====
// supply lockout, start-up pin control and fault restart sequencing of a flyback controller
`timescale 1ns/10ps
`default_nettype none
`include "flyback_consts.svh"

// Operation
// - switching enables at supply turn-on level, stops below turn-off level
// - start-up pin held low until turn-on, then sources current
// - wait state each cycle when peak below maximum; pin source stops
// - voltage sample over limit three cycles in a row raises over-voltage fault
// - over-voltage stops switching, keeps run bias until turn-off, then restarts
// - line current must pass run threshold within first three cycles
// - line current under stop level three cycles starts under-voltage fault
// - current-sense over limit three cycles shuts down into lockout restart
// - open current-sense pin reads high, so over-current fires after three cycles
// - first cycle only: sense minimum within 4 us of gate high, else abort
// - open upper divider stops switching; each restart gives a single on-time
// - open lower divider appears as output over-voltage
// - thermistor low at demagnetization end three cycles starts lockout restart
// - internal over-temperature starts lockout restart, repeating while present
// - constant-current mode, sense below limit for 120 ms sets latch
// - latch set: three lockout cycles without switching, cleared on fourth
// - condition persisting another 120 ms after resume re-enters the fault
// - lockout restart repeats for as long as a fault persists
// - first three cycles after turn-on limit peak current to minimum
module fault_restart_sequencer
	import flyback_pkg::*;
#(
	parameter int SOFTSHORT_CYCLES = (`SOFTSHORT_HOLD_MS * 1000000) / `CLK_PERIOD_NS
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic VDD_ABOVE_ON,
	input wire logic VDD_BELOW_OFF,
	input wire logic CYCLE_END,
	input wire logic GATE_DRIVE_OUTPUT,
	input wire logic VOLTAGE_SENSE_OVER,
	input wire logic LINE_RUN_THRESHOLD,
	input wire logic LINE_STOP_THRESHOLD,
	input wire logic CURRENT_SENSE_OVER,
	input wire logic SENSE_MIN_THRESHOLD,
	input wire logic THERMISTOR_STARTUP_PIN_LOW,
	input wire logic OVER_TEMPERATURE,
	input wire logic CC_MODE,
	input wire logic CC_UNDERVOLTAGE_THRESHOLD,
	input wire logic VOLTAGE_SENSE_OPEN,
	input wire logic PEAK_CURRENT_BELOW_MAXIMUM,
	output logic SWITCH_ENABLE,
	output logic STARTUP_SOURCE_ENABLE,
	output logic RUN_BIAS,
	output logic PEAK_CURRENT_MINIMUM,
	output logic CYCLE_ABORT,
	output logic OUTPUT_OVERVOLTAGE_FAULT,
	output logic CC_UNDERVOLTAGE_FAULT
);
	localparam int CS_CYCLES = `CS_CHECK_NS / `CLK_PERIOD_NS;
	localparam int CSW = $clog2(CS_CYCLES + 1);
	localparam int CCW = $clog2(SOFTSHORT_CYCLES + 1);
	localparam int NIN = `NUM_INPUTS;
	localparam int NCH = `NUM_CHANNELS;

	typedef struct packed {
		logic [NIN-1:0] sync1;
		logic [NIN-1:0] sync2;
		logic [NIN-1:0] prev;
		seq_t seq;
		logic [1:0] startup;
		logic line_ok;
		logic first_cycle;
		logic cs_armed;
		logic [CSW-1:0] cs_timer;
		logic [CCW-1:0] softshort_count;
		logic softshort_latch;
		logic [1:0] lockouts;
		logic waiting;
		logic overvolt_fault;
		logic abort;
	} seq_state_t;

	seq_state_t r;
	seq_state_t next_r;
	logic [NIN-1:0] pins;
	logic [NCH-1:0] ch_cond;
	logic [NCH-1:0] ch_clear;
	logic [NCH-1:0] ch_hit;
	logic cyc;
	logic gate_rise;
	logic running;
	logic softshort_cond;

	// gather analog comparator levels into one synchroniser word
	always_comb begin
		pins = '0;
		pins[`IX_VDD_ON] = VDD_ABOVE_ON;
		pins[`IX_VDD_OFF] = VDD_BELOW_OFF;
		pins[`IX_CYCLE_END] = CYCLE_END;
		pins[`IX_GATE] = GATE_DRIVE_OUTPUT;
		pins[`IX_VSENSE_OVER] = VOLTAGE_SENSE_OVER;
		pins[`IX_LINE_RUN] = LINE_RUN_THRESHOLD;
		pins[`IX_LINE_STOP] = LINE_STOP_THRESHOLD;
		pins[`IX_CS_OVER] = CURRENT_SENSE_OVER;
		pins[`IX_CS_MIN] = SENSE_MIN_THRESHOLD;
		pins[`IX_NTC_LOW] = THERMISTOR_STARTUP_PIN_LOW;
		pins[`IX_OVER_TEMP] = OVER_TEMPERATURE;
		pins[`IX_CC_MODE] = CC_MODE;
		pins[`IX_VSENSE_LOW] = CC_UNDERVOLTAGE_THRESHOLD;
		pins[`IX_VSENSE_OPEN] = VOLTAGE_SENSE_OPEN;
		pins[`IX_PEAK_LOW] = PEAK_CURRENT_BELOW_MAXIMUM;
	end

	// cycle events from synchronised edges
	assign cyc = r.sync2[`IX_CYCLE_END] && !r.prev[`IX_CYCLE_END];
	assign gate_rise = r.sync2[`IX_GATE] && !r.prev[`IX_GATE];
	assign running = (r.seq == SEQ_RUN);
	assign softshort_cond = r.sync2[`IX_CC_MODE] && r.sync2[`IX_VSENSE_LOW];

	// per-channel conditions; an open sense pin or lower divider reads as over-limit
	always_comb begin
		ch_cond = '0;
		ch_clear = {NCH{!running}};
		ch_cond[`CH_OVERVOLT] = r.sync2[`IX_VSENSE_OVER];
		ch_cond[`CH_LINE] = r.sync2[`IX_LINE_STOP];
		ch_clear[`CH_LINE] = !running || !r.line_ok;
		ch_cond[`CH_OC] = r.sync2[`IX_CS_OVER];
		ch_cond[`CH_NTC] = r.sync2[`IX_NTC_LOW];
	end

	// consecutive-cycle fault counters, emptied on every restart
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_chan
			consec_counter #(
				.N(`FAULT_CONSEC),
				.W(2)
			) u_count (
				.clk(CLK),
				.reset(RESET),
				.clear(ch_clear[g]),
				.strobe(cyc),
				.cond(ch_cond[g]),
				.hit(ch_hit[g])
			);
		end
	endgenerate

	// sequencer next state
	always_comb begin
		next_r = r;
		next_r.sync1 = pins;
		next_r.sync2 = r.sync1;
		next_r.prev = r.sync2;
		next_r.abort = 1'b0;
		case (r.seq)
			SEQ_START: begin
				next_r.overvolt_fault = 1'b0;
				next_r.waiting = 1'b0;
				if (r.sync2[`IX_VDD_ON]) begin
					if (r.softshort_latch && r.lockouts != 2'(`SOFTSHORT_SKIP_LOCKOUTS)) begin
						next_r.lockouts = r.lockouts + 2'(1);
						next_r.seq = SEQ_FAULT;
					end else begin
						next_r.softshort_latch = 1'b0;
						next_r.lockouts = '0;
						next_r.seq = SEQ_RUN;
						next_r.startup = '0;
						next_r.line_ok = 1'b0;
						next_r.first_cycle = 1'b1;
						next_r.cs_armed = 1'b0;
						next_r.cs_timer = '0;
						next_r.softshort_count = '0;
					end
				end
			end
			SEQ_RUN: begin
				// wait state between cycles while peak is under maximum
				if (cyc && r.sync2[`IX_PEAK_LOW]) begin
					next_r.waiting = 1'b1;
				end else if (gate_rise) begin
					next_r.waiting = 1'b0;
				end
				// start-up window and line run check
				if (cyc) begin
					next_r.first_cycle = 1'b0;
					if (r.startup != 2'(`STARTUP_CYCLES)) begin
						next_r.startup = r.startup + 2'(1);
					end
					if (r.sync2[`IX_LINE_RUN]) begin
						next_r.line_ok = 1'b1;
					end else if (!r.line_ok && r.startup == 2'(`STARTUP_CYCLES - 1)) begin
						next_r.seq = SEQ_FAULT;
					end
					if (r.sync2[`IX_VSENSE_OPEN]) begin
						next_r.seq = SEQ_FAULT;
					end
				end
				// sense pin short check on the first gate pulse only
				if (gate_rise && r.first_cycle) begin
					next_r.cs_armed = 1'b1;
					next_r.cs_timer = '0;
				end else if (r.cs_armed) begin
					if (r.sync2[`IX_CS_MIN]) begin
						next_r.cs_armed = 1'b0;
					end else if (r.cs_timer == CSW'(CS_CYCLES - 1)) begin
						next_r.cs_armed = 1'b0;
						next_r.abort = 1'b1;
						next_r.seq = SEQ_FAULT;
					end else begin
						next_r.cs_timer = r.cs_timer + CSW'(1);
					end
				end
				// soft-short timer, continuous condition only
				if (softshort_cond) begin
					if (r.softshort_count == CCW'(SOFTSHORT_CYCLES - 1)) begin
						next_r.softshort_latch = 1'b1;
						next_r.lockouts = '0;
						next_r.seq = SEQ_FAULT;
					end else begin
						next_r.softshort_count = r.softshort_count + CCW'(1);
					end
				end else begin
					next_r.softshort_count = '0;
				end
				// counted faults and over-temperature
				if (ch_hit[`CH_OVERVOLT]) begin
					next_r.overvolt_fault = 1'b1;
				end
				if (|ch_hit || r.sync2[`IX_OVER_TEMP]) begin
					next_r.seq = SEQ_FAULT;
				end
				if (r.sync2[`IX_VDD_OFF]) begin
					next_r.seq = SEQ_START;
				end
			end
			SEQ_FAULT: begin
				// discharge to turn-off, then power up again while fault lasts
				next_r.waiting = 1'b0;
				next_r.cs_armed = 1'b0;
				if (r.sync2[`IX_VDD_OFF]) begin
					next_r.seq = SEQ_START;
				end
			end
			default: begin
				next_r.seq = SEQ_START;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// outputs decoded from registered state
	assign SWITCH_ENABLE = running;
	assign STARTUP_SOURCE_ENABLE = (r.seq != SEQ_START) && !r.waiting;
	assign RUN_BIAS = (running && !r.waiting) || (r.seq == SEQ_FAULT && r.overvolt_fault);
	assign PEAK_CURRENT_MINIMUM = running && (r.startup != 2'(`STARTUP_CYCLES));
	assign CYCLE_ABORT = r.abort;
	assign OUTPUT_OVERVOLTAGE_FAULT = r.overvolt_fault;
	assign CC_UNDERVOLTAGE_FAULT = r.softshort_latch;

	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);

	stop_below_off_a: assert property (running && r.sync2[`IX_VDD_OFF] |=> !SWITCH_ENABLE)
		else $error("switching kept below turn-off");
	pin_low_start_a: assert property (r.seq == SEQ_START |-> !STARTUP_SOURCE_ENABLE)
		else $error("start-up pin sourced before turn-on");
	wait_no_source_a: assert property (running && cyc && r.sync2[`IX_PEAK_LOW]
		&& !gate_rise && !r.sync2[`IX_VDD_OFF] ##1 running |-> !STARTUP_SOURCE_ENABLE)
		else $error("source during wait state");
	overvolt_stop_a: assert property (running && ch_hit[`CH_OVERVOLT]
		|=> !SWITCH_ENABLE && OUTPUT_OVERVOLTAGE_FAULT && (r.seq == SEQ_START || RUN_BIAS))
		else $error("over-voltage not acted on");
	line_run_a: assert property (running && cyc && !r.line_ok
		&& !r.sync2[`IX_LINE_RUN] && r.startup == 2'(`STARTUP_CYCLES - 1) |=> !SWITCH_ENABLE)
		else $error("line run check missed");
	cs_short_a: assert property (running && r.cs_armed && !r.sync2[`IX_CS_MIN]
		&& r.cs_timer == CSW'(CS_CYCLES - 1) |=> CYCLE_ABORT && !SWITCH_ENABLE)
		else $error("sense short not aborted");
	otp_stop_a: assert property (running && r.sync2[`IX_OVER_TEMP] |=> !SWITCH_ENABLE)
		else $error("over-temperature ignored");
	softshort_time_a: assert property (running && softshort_cond
		&& r.softshort_count == CCW'(SOFTSHORT_CYCLES - 1)
		|=> CC_UNDERVOLTAGE_FAULT && !SWITCH_ENABLE)
		else $error("soft-short timer missed");
	softshort_skip_a: assert property (r.seq == SEQ_START && r.sync2[`IX_VDD_ON]
		&& r.softshort_latch && r.lockouts != 2'(`SOFTSHORT_SKIP_LOCKOUTS)
		|=> r.seq == SEQ_FAULT ##1 !SWITCH_ENABLE)
		else $error("switching during latched lockout");
	peak_min_a: assert property ($rose(SWITCH_ENABLE) |-> PEAK_CURRENT_MINIMUM)
		else $error("peak limit not at minimum on start");
endmodule : fault_restart_sequencer
`default_nettype wire

// ==== sim/afe_model.sv ====
// switching cycle and current-sense model facing the fault restart sequencer
`timescale 1ns/10ps
`default_nettype none
module afe_model (
	input wire logic clk,
	input wire logic run,
	input wire logic short_cs,
	output logic gate,
	output logic cend,
	output logic smin
);
	logic [5:0] cnt = 6'h00;
	// one switching cycle every 40 clocks, held at zero while switching is off
	always @(negedge clk) begin
		if (!run || cnt == 6'h27)
			cnt <= 6'h00;
		else
			cnt <= cnt + 6'h01;
	end
	// on-time, then end of demagnetization
	assign gate = run && cnt >= 6'h01 && cnt <= 6'h08;
	assign cend = run && cnt >= 6'h14 && cnt <= 6'h19;
	// sense rises soon after gate high unless the pin is shorted
	assign smin = gate && cnt >= 6'h03 && !short_cs;
endmodule : afe_model
`default_nettype wire

// ==== sim/tb_fault_restart_sequencer.sv ====
// self-checking bench of the fault restart sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_fault_restart_sequencer;
	logic clk = 1'b0, reset = 1'b1, vdd_on = 1'b0, vdd_off = 1'b0, vsense_over = 1'b0;
	logic line_run = 1'b1, line_stop = 1'b0, cs_over = 1'b0, ntc_low = 1'b0, otemp = 1'b0;
	logic cc_mode = 1'b0, cc_thr = 1'b0, vsense_open = 1'b0, peak_low = 1'b0, short_cs = 1'b0;
	wire logic gate, cend, smin, sw, src, bias, pmin, abort, ovf, ccf;
	int bad_count = 0, total_checks = 0, ab_n = 0;
	wire logic [5:0] outs = {sw, src, bias, pmin, ovf, ccf};
	wire logic [5:0] fo = {2'b00, sw, bias, ovf, ccf};

	fault_restart_sequencer #(.SOFTSHORT_CYCLES(50)) u_dut (.CLK(clk), .RESET(reset),
		.VDD_ABOVE_ON(vdd_on), .VDD_BELOW_OFF(vdd_off), .CYCLE_END(cend),
		.GATE_DRIVE_OUTPUT(gate), .VOLTAGE_SENSE_OVER(vsense_over),
		.LINE_RUN_THRESHOLD(line_run),
		.LINE_STOP_THRESHOLD(line_stop), .CURRENT_SENSE_OVER(cs_over), .SENSE_MIN_THRESHOLD(smin),
		.THERMISTOR_STARTUP_PIN_LOW(ntc_low), .OVER_TEMPERATURE(otemp), .CC_MODE(cc_mode),
		.CC_UNDERVOLTAGE_THRESHOLD(cc_thr), .VOLTAGE_SENSE_OPEN(vsense_open),
		.PEAK_CURRENT_BELOW_MAXIMUM(peak_low), .SWITCH_ENABLE(sw), .STARTUP_SOURCE_ENABLE(src),
		.RUN_BIAS(bias), .PEAK_CURRENT_MINIMUM(pmin), .CYCLE_ABORT(abort),
		.OUTPUT_OVERVOLTAGE_FAULT(ovf), .CC_UNDERVOLTAGE_FAULT(ccf));
	afe_model u_afe (.clk(clk), .run(sw), .short_cs(short_cs), .gate(gate), .cend(cend),
		.smin(smin));

	// clock and abort pulse counter
	initial forever #5 clk = ~clk;
	always @(negedge clk) if (abort === 1'b1) ab_n++;

	task chk(input logic [5:0] got, input logic [5:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task close_out;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	task clk_n(input int n);
		repeat (n) @(negedge clk);
	endtask : clk_n
	task strobes(input int n);
		repeat (n) @(posedge cend);
		clk_n(4);
	endtask : strobes
	// supply charges past turn-on, then sags inside the hysteresis band
	task up;
		vdd_off = 1'b0;
		vdd_on = 1'b1;
		clk_n(6);
		vdd_on = 1'b0;
	endtask : up
	task down;
		vdd_off = 1'b1;
		clk_n(6);
		vdd_off = 1'b0;
		clk_n(2);
	endtask : down

	task t_start;
		chk(outs, 6'h00);
		up;
		chk(outs, 6'h3C);
		strobes(3);
		chk(outs, 6'h38);
	endtask : t_start
	task t_wait;
		peak_low = 1'b1;
		strobes(1);
		chk(outs, 6'h20);
		peak_low = 1'b0;
		@(posedge gate);
		clk_n(4);
		chk(outs, 6'h38);
	endtask : t_wait
	task t_ov;
		vsense_over = 1'b1;
		strobes(2);
		vsense_over = 1'b0;
		strobes(1);
		vsense_over = 1'b1;
		strobes(2);
		chk(outs, 6'h38);
		strobes(1);
		chk(fo, 6'h06);
		vsense_over = 1'b0;
		down;
		chk(outs, 6'h00);
	endtask : t_ov
	task t_line_run;
		line_run = 1'b0;
		up;
		strobes(2);
		chk(fo, 6'h0C);
		strobes(1);
		chk(fo, 6'h00);
		line_run = 1'b1;
		down;
	endtask : t_line_run
	task t_stop;
		up;
		strobes(1);
		line_run = 1'b0;
		line_stop = 1'b1;
		strobes(3);
		chk(fo, 6'h00);
		line_run = 1'b1;
		line_stop = 1'b0;
		down;
	endtask : t_stop
	task t_oc;
		up;
		cs_over = 1'b1;
		strobes(3);
		chk(fo, 6'h00);
		cs_over = 1'b0;
		down;
	endtask : t_oc
	task t_ntc;
		up;
		ntc_low = 1'b1;
		strobes(3);
		chk(fo, 6'h00);
		ntc_low = 1'b0;
		down;
		// released pull-down lets the next power-up run, then a plain supply drop stops it
		up;
		chk(fo, 6'h0C);
		down;
		chk(outs, 6'h00);
	endtask : t_ntc
	task t_open;
		vsense_open = 1'b1;
		repeat (2) begin
			up;
			strobes(1);
			chk(fo, 6'h00);
			down;
		end
		vsense_open = 1'b0;
	endtask : t_open
	task t_otemp;
		otemp = 1'b1;
		repeat (2) begin
			up;
			clk_n(4);
			chk(fo, 6'h00);
			down;
		end
		otemp = 1'b0;
	endtask : t_otemp
	task t_short;
		chk(6'(ab_n), 6'h00);
		short_cs = 1'b1;
		up;
		clk_n(420);
		chk(6'(ab_n), 6'h01);
		chk(fo, 6'h00);
		short_cs = 1'b0;
		down;
	endtask : t_short
	task t_cc;
		cc_mode = 1'b1;
		cc_thr = 1'b1;
		up;
		clk_n(60);
		chk(fo, 6'h01);
		repeat (3) begin
			down;
			up;
			chk(fo, 6'h01);
		end
		down;
		up;
		chk(fo, 6'h0C);
		clk_n(60);
		chk(fo, 6'h01);
		cc_mode = 1'b0;
		cc_thr = 1'b0;
		down;
	endtask : t_cc

	// main sequence
	initial begin
		clk_n(2);
		reset = 1'b0;
		clk_n(2);
		t_start;
		t_wait;
		t_ov;
		t_line_run;
		t_stop;
		t_oc;
		t_ntc;
		t_open;
		t_otemp;
		t_short;
		t_cc;
		close_out;
	end
	// watchdog well beyond the 1,636 clocks the run needs
	initial begin
		#500000;
		bad_count++;
		close_out;
	end
endmodule : tb_fault_restart_sequencer
`default_nettype wire
